// ---- common/arr_pkg.sv ----
// arr_pkg: constants and types for the converter rate selection and output pair routing bank.
// assumes: a 16-bit register port with 16-bit data; the consumers interpret the decoded fields.
package arr_pkg;

  // register port and map
  localparam int ARR_ADDR_W = 16;
  localparam int ARR_DATA_W = 16;
  localparam logic [15:0] ARR_RATE_BASE = 16'hF140;
  localparam logic [15:0] ARR_ROUTE_BASE = 16'hF180;
  localparam logic [15:0] ARR_STATUS_ADDR = 16'hF1F0;
  localparam int ARR_NUM_CONV = 8;
  localparam int ARR_NUM_PAIRS = 24;
  localparam logic [4:0] ARR_LAST_PAIR = 5'h17;
  localparam logic [15:0] ARR_RESET_VALUE = 16'h0000;

  // field layout of the rate register
  localparam int ARR_RATE_LSB = 0;
  localparam int ARR_RATE_W = 4;
  // field layout of the route register
  localparam int ARR_ORIGIN_LSB = 0;
  localparam int ARR_ORIGIN_W = 3;
  localparam int ARR_PICK_LSB = 3;
  localparam int ARR_PICK_W = 3;
  localparam int ARR_ROUTE_W = 6;
  // field layout of the status register
  localparam int ARR_LEVEL_LSB = 0;
  localparam int ARR_DROP_LSB = 8;

  // lane boundaries in pair index
  localparam logic [4:0] ARR_LANE1_FIRST = 5'h08;
  localparam logic [4:0] ARR_LANE2_FIRST = 5'h10;
  localparam logic [4:0] ARR_LANE3_FIRST = 5'h14;

  // output buffer
  localparam int ARR_FIFO_DEPTH = 16;
  localparam int ARR_SAMPLE_W = 32;

  // where a converter takes its output timing
  typedef enum logic [2:0] {
    ARR_SRC_NONE = 3'h0,
    ARR_SRC_LANE = 3'h1,
    ARR_SRC_CORE = 3'h2,
    ARR_SRC_GEN1 = 3'h3,
    ARR_SRC_GEN2 = 3'h4
  } arr_rate_src_t;

  // decoded target rate: reference, lane for lane-locked codes, ratio mul/div
  typedef struct packed {
    arr_rate_src_t src;
    logic [1:0] lane;
    logic [2:0] mul;
    logic [2:0] div;
  } arr_rate_sel_t;

  // source of one output channel pair
  typedef enum logic [2:0] {
    ARR_ORG_OFF = 3'h0,
    ARR_ORG_SIN = 3'h1,
    ARR_ORG_CORE = 3'h2,
    ARR_ORG_CONV = 3'h3,
    ARR_ORG_MIC01 = 3'h4,
    ARR_ORG_MIC23 = 3'h5
  } arr_origin_t;

  // one routed output pair as it leaves the buffer
  typedef struct packed {
    logic active;
    logic [1:0] lane;
    logic [2:0] slot;
    logic [31:0] left;
    logic [31:0] right;
  } arr_out_word_t;

  localparam int ARR_WORD_W = $bits(arr_out_word_t);

endpackage : arr_pkg

// ---- hdl/arr_route_rate.sv ----
// arr_route_rate: rate selection for eight stereo converters and source routing for the
// twenty-four serial output channel pairs, with a buffered stream of routed pairs.
// assumes: all inputs synchronous to REF_CLK; the register master never issues read and
// write together; the serial output side pulls words from OUT_* at its own pace.
// assumes also: reset is synchronous and held for at least one rising edge.
// assumes also: converter, microphone and port data stand steady beside a request.
// limitation: the block picks rates and routes words; it makes no sample clocks itself.
// limitation: converter input selection and the spdif transmitter source live elsewhere.
// hazard: a route change applies to the next accepted request, never to queued words.
// hazard: a rate change reaches RATE_SEL two edges after the write strobe.
//
// Behaviour
// R01 - each converter resamples any input rate to its register's target rate
// R02 - eight rate registers at consecutive addresses, register k drives converter k
// R03 - rate register: 4-bit code in low bits, upper bits reserved, reset zero
// R04 - rate code zero selects no output rate and no timing reference
// R05 - codes one to four lock to serial output lanes zero to three
// R06 - code five locks to the core frame rate
// R07 - codes six, seven, eight give first generator rate times one, two, four
// R08 - code nine halves, code eleven quarters the first generator rate
// R09 - codes ten and twelve give second generator rate over three and six
// R10 - codes thirteen to fifteen behave as code zero
// R11 - twenty-four route registers at consecutive addresses, register k feeds pair k
// R12 - registers 0-7 feed lane zero, 8-15 feed lane one
// R13 - registers 16-19 feed lane two, 20-23 feed lane three
// R14 - converter pick in bits five to three, upper bits reserved, reset zero
// R15 - a pair takes serial input, core output, converter or microphone data
// R16 - origin zero off, one serial input, two core output, three picked converter
// R17 - origin four microphones zero/one, five microphones two/three
//
// Local design decision: the plain strobed port.
`timescale 1ns/100ps

// arr_fifo: synchronous first-in first-out buffer with valid/ready on both sides
// depth must be a power of two, since the pointer wrap relies on it
// level counts queued words from 0 to DEPTH, so it needs one bit more than an index
// no bypass: a word pushed on one edge shows at the head right after that same edge, never while it is offered
module arr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW:0] wr_ptr;
  logic [PW:0] rd_ptr;
  logic [PW:0] next_wr_ptr;
  logic [PW:0] next_rd_ptr;
  wire do_push;
  wire do_pop;
  wire is_full;
  wire is_empty;

  // pointers carry one extra bit so full and empty differ
  assign is_empty = (wr_ptr == rd_ptr);
  assign is_full = (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]) && (wr_ptr[PW] != rd_ptr[PW]);
  assign in_ready = !is_full;
  assign out_valid = !is_empty;
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;
  assign next_wr_ptr = do_push ? wr_ptr + 1'b1 : wr_ptr;
  assign next_rd_ptr = do_pop ? rd_ptr + 1'b1 : rd_ptr;
  assign level = wr_ptr - rd_ptr;
  // storage is flip-flops, so the head word is a registered value
  assign out_data = store[rd_ptr[PW-1:0]];

  // pointer update
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // storage write; contents need no reset since empty hides them
  always_ff @(posedge clk) begin
    if (do_push) begin
      store[wr_ptr[PW-1:0]] <= in_data;
    end
  end
endmodule : arr_fifo

// register map as software sees it:
//   rate group   base + k, k = 0..7, code in bits 3:0, bits 15:4 read zero
//   route group  base + k, k = 0..23, origin in 2:0, converter in 5:3, 15:6 read zero
//   status word  buffer level in 4:0, dropped request count in 15:8
//   anything else reads zero and ignores writes
//
// rate codes and the reference each one picks:
//   0  none
//   1  lane zero frame rate
//   2  lane one frame rate
//   3  lane two frame rate
//   4  lane three frame rate
//   5  core frame rate
//   6  first generator, ratio one
//   7  first generator, times two
//   8  first generator, times four
//   9  first generator, half
//   10 second generator, one third
//   11 first generator, quarter
//   12 second generator, one sixth
//   13-15 none, so a stray write stops a converter rather than guessing a rate
//
// origin codes of a route register:
//   0 pair off
//   1 matching serial input pair
//   2 matching core output pair
//   3 converter named by the pick field
//   4 microphones zero and one
//   5 microphones two and three
//   6 and 7 undefined: the word is still queued, marked inactive, with zero data
//
// pair index to lane and slot:
//   pairs 0-7 lane zero, slots 0-7
//   pairs 8-15 lane one, slots 0-7
//   pairs 16-19 lane two, slots 0-3
//   pairs 20-23 lane three, slots 0-3
//
// trade-off: every in-range request is queued, even for a silent pair, so the consumer sees
// one word per in-range request and never has to count gaps.
module arr_route_rate
  import arr_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic [ARR_ADDR_W-1:0] REG_ADDR,
  input wire logic [ARR_DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [ARR_DATA_W-1:0] REG_RDATA,
  output arr_rate_sel_t [ARR_NUM_CONV-1:0] RATE_SEL,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic [4:0] REQ_PAIR,
  input wire logic [2*ARR_SAMPLE_W-1:0] REQ_SIN_DATA,
  input wire logic [2*ARR_SAMPLE_W-1:0] REQ_CORE_DATA,
  input wire logic [ARR_NUM_CONV-1:0][2*ARR_SAMPLE_W-1:0] CONV_DATA,
  input wire logic [3:0][ARR_SAMPLE_W-1:0] MIC_DATA,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output arr_out_word_t OUT_WORD
);

  localparam int LVL_W = $clog2(ARR_FIFO_DEPTH) + 1;

  // decode of one rate code into reference and ratio
  function automatic arr_rate_sel_t rate_decode(input logic [ARR_RATE_W-1:0] code);
    arr_rate_sel_t s;
    s = '{src: ARR_SRC_NONE, lane: 2'h0, mul: 3'h1, div: 3'h1};
    unique case (code)
      4'h0: s.src = ARR_SRC_NONE; // R04
      4'h1: begin
        s.src = ARR_SRC_LANE; // R05
        s.lane = 2'h0;
      end
      4'h2: begin
        s.src = ARR_SRC_LANE; // R05
        s.lane = 2'h1;
      end
      4'h3: begin
        s.src = ARR_SRC_LANE; // R05
        s.lane = 2'h2;
      end
      4'h4: begin
        s.src = ARR_SRC_LANE; // R05
        s.lane = 2'h3;
      end
      4'h5: s.src = ARR_SRC_CORE; // R06
      4'h6: s.src = ARR_SRC_GEN1; // R07
      4'h7: begin
        s.src = ARR_SRC_GEN1; // R07
        s.mul = 3'h2;
      end
      4'h8: begin
        s.src = ARR_SRC_GEN1; // R07
        s.mul = 3'h4;
      end
      4'h9: begin
        s.src = ARR_SRC_GEN1; // R08
        s.div = 3'h2;
      end
      4'hA: begin
        s.src = ARR_SRC_GEN2; // R09
        s.div = 3'h3;
      end
      4'hB: begin
        s.src = ARR_SRC_GEN1; // R08
        s.div = 3'h4;
      end
      4'hC: begin
        s.src = ARR_SRC_GEN2; // R09
        s.div = 3'h6;
      end
      default: s.src = ARR_SRC_NONE; // R10
    endcase
    return s;
  endfunction : rate_decode

  // lane and slot of an output pair index
  function automatic logic [4:0] pair_place(input logic [4:0] pair);
    logic [4:0] p;
    p = 5'h00;
    if (pair < ARR_LANE1_FIRST) begin
      p = {2'h0, pair[2:0]}; // R12
    end else if (pair < ARR_LANE2_FIRST) begin
      p = {2'h1, pair[2:0]}; // R12
    end else if (pair < ARR_LANE3_FIRST) begin
      p = {2'h2, 1'b0, pair[1:0]}; // R13
    end else begin
      p = {2'h3, 1'b0, 2'(pair - ARR_LANE3_FIRST)}; // R13
    end
    return p;
  endfunction : pair_place

  logic [ARR_RATE_W-1:0] rate_reg [ARR_NUM_CONV];
  logic [ARR_ROUTE_W-1:0] route_reg [ARR_NUM_PAIRS];
  logic [ARR_DATA_W-1:0] next_rdata;
  logic [7:0] drop_count;
  logic [LVL_W-1:0] fifo_level;
  logic [ARR_WORD_W-1:0] fifo_out;

  // address decode of the three register groups
  wire hit_rate = (REG_ADDR[15:3] == ARR_RATE_BASE[15:3]); // R02
  wire hit_route = (REG_ADDR[15:5] == ARR_ROUTE_BASE[15:5]) &&
                   (REG_ADDR[4:0] <= ARR_LAST_PAIR); // R11
  wire hit_status = (REG_ADDR == ARR_STATUS_ADDR);
  wire [2:0] rate_idx = REG_ADDR[2:0];
  wire [4:0] route_idx = REG_ADDR[4:0];

  // register writes; reserved bits are not stored and read back zero
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      for (int i = 0; i < ARR_NUM_CONV; i++) begin
        rate_reg[i] <= ARR_RESET_VALUE[ARR_RATE_W-1:0]; // R03
      end
      for (int i = 0; i < ARR_NUM_PAIRS; i++) begin
        route_reg[i] <= ARR_RESET_VALUE[ARR_ROUTE_W-1:0]; // R14
      end
    end else if (REG_WR) begin
      if (hit_rate) begin
        rate_reg[rate_idx] <= REG_WDATA[ARR_RATE_LSB +: ARR_RATE_W]; // R03
      end
      if (hit_route) begin
        route_reg[route_idx] <= REG_WDATA[ARR_ROUTE_W-1:0]; // R14
      end
    end
  end

  // read mux; unmapped addresses answer zero
  always_comb begin
    next_rdata = '0;
    if (hit_rate) begin
      next_rdata[ARR_RATE_LSB +: ARR_RATE_W] = rate_reg[rate_idx];
    end else if (hit_route) begin
      next_rdata[ARR_ROUTE_W-1:0] = route_reg[route_idx];
    end else if (hit_status) begin
      next_rdata[ARR_LEVEL_LSB +: LVL_W] = fifo_level;
      next_rdata[ARR_DROP_LSB +: 8] = drop_count;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge REF_CLK) begin
    if (!NRST) REG_RDATA <= '0;
    else REG_RDATA <= REG_RD ? next_rdata : '0;
  end

  // decoded rate per converter, registered so consumers see clean levels
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      for (int i = 0; i < ARR_NUM_CONV; i++) begin
        RATE_SEL[i] <= rate_decode(ARR_RESET_VALUE[ARR_RATE_W-1:0]);
      end
    end else begin
      for (int i = 0; i < ARR_NUM_CONV; i++) begin
        RATE_SEL[i] <= rate_decode(rate_reg[i]); // R01
      end
    end
  end

  // routing of the requested pair
  // the route is read at the taking edge, so the queued word keeps the route of its time
  wire pair_ok = (REQ_PAIR <= ARR_LAST_PAIR);
  wire [ARR_ROUTE_W-1:0] pair_cfg = pair_ok ? route_reg[REQ_PAIR] : '0;
  wire [2:0] origin = pair_cfg[ARR_ORIGIN_LSB +: ARR_ORIGIN_W];
  wire [2:0] conv_pick = pair_cfg[ARR_PICK_LSB +: ARR_PICK_W];
  wire [4:0] place = pair_place(REQ_PAIR);
  wire [63:0] conv_pair = CONV_DATA[conv_pick]; // R14
  wire [63:0] mic01 = {MIC_DATA[0], MIC_DATA[1]};
  wire [63:0] mic23 = {MIC_DATA[2], MIC_DATA[3]};
  // codes six and seven have no meaning and leave the pair silent
  wire [63:0] routed =
      (origin == ARR_ORG_SIN) ? REQ_SIN_DATA : // R16
      (origin == ARR_ORG_CORE) ? REQ_CORE_DATA : // R16
      (origin == ARR_ORG_CONV) ? conv_pair : // R16
      (origin == ARR_ORG_MIC01) ? mic01 : // R17
      (origin == ARR_ORG_MIC23) ? mic23 : 64'h0; // R17
  wire routed_active = (origin >= ARR_ORG_SIN) && (origin <= ARR_ORG_MIC23); // R15

  // word to queue: lane and slot let the consumer place it without the pair index
  arr_out_word_t push_word;
  assign push_word.active = routed_active;
  assign push_word.lane = place[4:3];
  assign push_word.slot = place[2:0];
  assign push_word.left = routed[63:32];
  assign push_word.right = routed[31:0];

  // out-of-range pair requests are consumed and dropped, never buffered
  wire fifo_in_ready;
  wire push_valid = REQ_VALID && pair_ok;
  assign REQ_READY = fifo_in_ready || !pair_ok;
  wire drop = REQ_VALID && !pair_ok;

  // wrapping count of dropped requests, visible in the status word
  always_ff @(posedge REF_CLK) begin
    if (!NRST) drop_count <= '0;
    else if (drop) drop_count <= drop_count + 8'h01;
  end

  // sixteen words of slack between request side and serial output side
  // when full, REQ_READY falls for in-range pairs and those requests wait; none of them is lost
  arr_fifo #(
    .WIDTH(ARR_WORD_W),
    .DEPTH(ARR_FIFO_DEPTH)
  ) u_fifo (
    .clk(REF_CLK),
    .rst_n(NRST),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .in_data(push_word),
    .out_valid(OUT_VALID),
    .out_ready(OUT_READY),
    .out_data(fifo_out),
    .level(fifo_level)
  );

  assign OUT_WORD = arr_out_word_t'(fifo_out);

endmodule : arr_route_rate

// ---- tb/arr_sink_model.sv ----
// arr_sink_model: serial output side pulling routed pairs from the buffer
// assumes: the bench sets stall; a word is taken on each valid and ready edge
`timescale 1ns/100ps
module arr_sink_model
  import arr_pkg::*;
(
  input wire logic clk,
  input wire logic stall,
  input wire logic valid,
  input wire arr_out_word_t word,
  output logic ready,
  output arr_out_word_t last,
  output int taken
);
  // a stalled frame holds the buffer back, which is how back-pressure is tested
  assign ready = !stall;
  initial taken = 0;
  // keep the last accepted word and a count for the bench
  always @(posedge clk) begin
    if (valid && ready) begin
      last <= word;
      taken <= taken + 1;
    end
  end
endmodule : arr_sink_model

// ---- tb/arr_route_rate_assertions.sv ----
// arr_route_rate_checker: port assertions for the rate and route bank
// assumes: bound to arr_route_rate; one clock, reset low
`timescale 1ns/100ps
module arr_route_rate_checker
  import arr_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic [15:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_RDATA,
  input wire arr_rate_sel_t [ARR_NUM_CONV-1:0] RATE_SEL,
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire logic [4:0] REQ_PAIR,
  input wire logic OUT_VALID,
  input wire logic OUT_READY,
  input wire arr_out_word_t OUT_WORD
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  // decode and the lane a pair must land in
  wire rate_hit = REG_ADDR[15:3] == 13'h1E28;
  wire route_hit = REG_ADDR >= 16'hF180 && REG_ADDR <= 16'hF197;
  wire [3:0] code = REG_WDATA[3:0];
  // lane that a lane-locked code one to four names
  wire [1:0] lane_w = code[1:0] - 2'h1;
  wire [1:0] lane_p = REQ_PAIR > 5'h13 ? 2'h3 : REQ_PAIR > 5'h0F ? 2'h2 : {1'b0, REQ_PAIR[3]};
  sequence s_rate_wr;
    REG_WR && rate_hit;
  endsequence
  sequence s_take_empty;
    REQ_VALID && REQ_READY && REQ_PAIR < 5'h18 && !OUT_VALID;
  endsequence
  a_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 16'h0000)
    else $error("read data not zero");
  a_rate_resv: assert property (REG_RD && rate_hit |=> REG_RDATA[15:4] == 12'h000)
    else $error("rate reserved bits set");
  a_route_resv: assert property (REG_RD && route_hit |=> REG_RDATA[15:6] == 10'h000)
    else $error("route reserved bits set");
  a_rate_none: assert property (s_rate_wr ##0 (code == 4'h0 || code > 4'hC)
    |=> ##1 RATE_SEL[$past(REG_ADDR[2:0], 2)].src == ARR_SRC_NONE) else $error("rate not none");
  a_lane_lock: assert property (s_rate_wr ##0 code inside {[4'h1:4'h4]}
    |=> ##1 RATE_SEL[$past(REG_ADDR[2:0], 2)].lane == $past(lane_w, 2))
    else $error("wrong locked lane");
  a_out_hold: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_WORD))
    else $error("head word moved");
  a_pair_lane: assert property (s_take_empty |=> OUT_VALID && OUT_WORD.lane == $past(lane_p))
    else $error("pair on wrong lane");
  a_drop_ready: assert property (REQ_PAIR > 5'h17 |-> REQ_READY)
    else $error("bad pair refused");
endmodule : arr_route_rate_checker
bind arr_route_rate arr_route_rate_checker arr_route_rate_checker_i (.*);

// ---- tb/arr_route_rate_tb.sv ----
// arr_route_rate_tb: self-checking bench for rate selection and pair routing
// assumes: package, design, sink model and checker compiled first
`timescale 1ns/100ps
module arr_route_rate_tb;
  import arr_pkg::*;
  localparam logic [63:0] SIN = 64'h5151_0001_5252_0002;
  localparam logic [63:0] CORE = 64'hC0E0_0001_C0E0_0002;
  localparam logic [2:0] SRC [16] = '{3'h0, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h3, 3'h3, 3'h3,
    3'h3, 3'h4, 3'h3, 3'h4, 3'h0, 3'h0, 3'h0};
  localparam logic [5:0] RAT [16] = '{6'h09, 6'h09, 6'h09, 6'h09, 6'h09, 6'h09, 6'h09, 6'h11,
    6'h21, 6'h0A, 6'h0B, 6'h0C, 6'h0E, 6'h09, 6'h09, 6'h09};
  // pair and {pick, origin}, spread over all four lanes
  localparam logic [4:0] PR [9] = '{5'h00, 5'h09, 5'h11, 5'h0F, 5'h17, 5'h14, 5'h05, 5'h0C, 5'h13};
  localparam logic [5:0] RT [9] = '{6'h01, 6'h02, 6'h2B, 6'h3B, 6'h04, 6'h05, 6'h00, 6'h06, 6'h07};
  logic clk, nrst, wr, rd, req_valid, stall, req_ready, out_valid, out_ready;
  logic [15:0] addr, wdata, rdata;
  logic [4:0] req_pair;
  logic [7:0][63:0] conv;
  logic [3:0][31:0] mic;
  arr_rate_sel_t [7:0] rate_sel;
  arr_out_word_t out_word, last;
  int taken, err_total, checks_done;
  arr_route_rate arr_route_rate_i (.REF_CLK(clk), .NRST(nrst), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .RATE_SEL(rate_sel),
    .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_PAIR(req_pair), .REQ_SIN_DATA(SIN),
    .REQ_CORE_DATA(CORE), .CONV_DATA(conv), .MIC_DATA(mic), .OUT_VALID(out_valid),
    .OUT_READY(out_ready), .OUT_WORD(out_word));
  arr_sink_model arr_sink_model_i (.clk(clk), .stall(stall), .valid(out_valid),
    .word(out_word), .ready(out_ready), .last(last), .taken(taken));
  task automatic chk(string what, logic [69:0] seen, logic [69:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wreg(logic [15:0] a, logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  // read data stand only in the cycle after the read strobe
  task automatic rreg(logic [15:0] a, logic [15:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rdata", 70'(rdata), 70'(exp));
  endtask : rreg
  task automatic req(logic [4:0] p);
    @(posedge clk);
    req_valid <= 1'b1;
    req_pair <= p;
    @(negedge clk);
    for (int w = 0; w < 40 && !req_ready; w++) @(negedge clk);
    @(posedge clk);
    req_valid <= 1'b0;
  endtask : req
  function automatic arr_out_word_t exp_word(logic [4:0] p, logic [5:0] r);
    logic [63:0] d;
    case (r[2:0])
      3'h1: d = SIN;
      3'h2: d = CORE;
      3'h3: d = conv[r[5:3]];
      3'h4: d = {mic[0], mic[1]};
      3'h5: d = {mic[2], mic[3]};
      default: d = 64'h0;
    endcase
    exp_word.active = r[2:0] inside {[3'h1:3'h5]};
    exp_word.lane = p > 5'h13 ? 2'h3 : p > 5'h0F ? 2'h2 : {1'b0, p[3]};
    exp_word.slot = p > 5'h0F ? {1'b0, p[1:0]} : p[2:0];
    {exp_word.left, exp_word.right} = d;
  endfunction : exp_word
  task automatic t_reset;
    @(negedge clk);
    for (int k = 0; k < 8; k++) chk("src0", 70'(rate_sel[k].src), 70'(ARR_SRC_NONE));
    for (int k = 0; k < 32; k++) rreg(16'hF140 + 16'(k < 8 ? k : k + 56), 16'h0000);
    wreg(16'hF198, 16'hFFFF);
    rreg(16'hF198, 16'h0000);
  endtask : t_reset
  task automatic t_rate;
    arr_rate_sel_t s;
    for (int c = 0; c < 16; c++) begin
      wreg(16'hF140 + 16'(c % 8), 16'hFFF0 | 16'(c));
      @(posedge clk);
      @(negedge clk);
      s = rate_sel[c % 8];
      chk("src", 70'(s.src), 70'(SRC[c]));
      if (c > 0 && c < 5) chk("lane", 70'(s.lane), 70'(c - 1));
      if (c > 5 && c < 13) chk("ratio", 70'({s.mul, s.div}), 70'(RAT[c]));
      rreg(16'hF140 + 16'(c % 8), 16'(c));
    end
  endtask : t_rate
  task automatic t_route;
    int n;
    for (int i = 0; i < 9; i++) begin
      wreg(16'hF180 + 16'(PR[i]), 16'hFFC0 | 16'(RT[i]));
      rreg(16'hF180 + 16'(PR[i]), 16'(RT[i]));
      n = taken;
      req(PR[i]);
      for (int w = 0; w < 20 && taken == n; w++) @(negedge clk);
      chk("word", 70'(last), 70'(exp_word(PR[i], RT[i])));
    end
  endtask : t_route
  // fill with the sink stalled, one bad pair dropped, then drain
  task automatic t_fill;
    int n;
    @(posedge clk);
    stall <= 1'b1;
    req(5'h18);
    for (int k = 0; k < 16; k++) req(5'(k));
    @(negedge clk);
    chk("full", 70'(req_ready), 70'(1'b0));
    rreg(16'hF1F0, 16'h0110);
    n = taken;
    @(posedge clk);
    stall <= 1'b0;
    for (int w = 0; w < 60 && taken < n + 16; w++) @(negedge clk);
    chk("drained", 70'(taken - n), 70'(16));
    rreg(16'hF1F0, 16'h0100);
  endtask : t_fill
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // reset for three cycles, then the scenarios in turn
  initial begin
    {nrst, wr, rd, req_valid, stall, addr, wdata, req_pair, err_total, checks_done} = '0;
    for (int k = 0; k < 8; k++) conv[k] = {32'hC0C0_0000 + 32'(k), 32'hD0D0_0000 + 32'(k)};
    mic = {32'h3333_0003, 32'h2222_0002, 32'h1111_0001, 32'h0A0A_0000};
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_rate;
    t_route;
    t_fill;
    close_out;
  end
  // a hang counts as a mismatch
  initial begin
    #200000;
    err_total++;
    close_out;
  end
endmodule : arr_route_rate_tb
